// file: common/ecs_pkg.sv
`default_nettype none

package ecs_pkg;

  // ==========================================================================
  // Source selections
  // ==========================================================================
  typedef enum logic [3:0] {
    ECS_START_OFF      = 4'h0,
    ECS_START_ACQ      = 4'h1,
    ECS_START_EXP_BEG  = 4'h2,
    ECS_START_EXP_FIN  = 4'h3,
    ECS_START_IMAGE    = 4'h4,
    ECS_START_REJECT   = 4'h5,
    ECS_START_LINE_ONE = 4'h6,
    ECS_START_LINE_TWO = 4'h7,
    ECS_START_TIMER    = 4'h8,
    ECS_START_COUNTER  = 4'h9
  } ecs_start_src_t;

  typedef enum logic [3:0] {
    ECS_INC_OFF      = 4'h0,
    ECS_INC_ACQ      = 4'h1,
    ECS_INC_EXP_BEG  = 4'h2,
    ECS_INC_EXP_FIN  = 4'h3,
    ECS_INC_IMAGE    = 4'h4,
    ECS_INC_LINE_ONE = 4'h5,
    ECS_INC_LINE_TWO = 4'h6,
    ECS_INC_ENCODER  = 4'h7,
    ECS_INC_USEC     = 4'h8,
    ECS_INC_TIMER    = 4'h9,
    ECS_INC_REJECT   = 4'hA
  } ecs_inc_src_t;

  typedef enum logic [3:0] {
    ECS_CLR_CMD      = 4'h0,
    ECS_CLR_ACQ_BEG  = 4'h1,
    ECS_CLR_ACQ_FIN  = 4'h2,
    ECS_CLR_EXP_BEG  = 4'h3,
    ECS_CLR_EXP_FIN  = 4'h4,
    ECS_CLR_LINE_ONE = 4'h5,
    ECS_CLR_LINE_TWO = 4'h6,
    ECS_CLR_TIMER    = 4'h7,
    ECS_CLR_COUNTER  = 4'h8
  } ecs_clr_src_t;

  typedef enum logic [1:0] {
    ECS_EDGE_UP     = 2'h0,
    ECS_EDGE_DOWN   = 2'h1,
    ECS_EDGE_EITHER = 2'h2
  } ecs_edge_t;

  // Status, one-hot
  typedef enum logic [4:0] {
    ECS_ST_IDLE     = 5'h01,
    ECS_ST_WAIT     = 5'h02,
    ECS_ST_ACTIVE   = 5'h04,
    ECS_ST_DONE     = 5'h08,
    ECS_ST_OVERFLOW = 5'h10
  } ecs_state_t;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic acq_begin_event;
    logic acq_finish_event;
    logic expose_begin_event;
    logic expose_finish_event;
    logic image_begin_event;
    logic rejected_trigger_event;
    logic timer_one_done;
    logic shaft_encoder_ticks;
  } ecs_events_t;

  typedef struct packed {
    ecs_start_src_t start_source_select;
    ecs_edge_t      start_edge_select;
    ecs_inc_src_t   increment_source_select;
    ecs_edge_t      increment_edge_select;
    ecs_clr_src_t   clear_source_select;
    ecs_edge_t      clear_edge_select;
  } ecs_config_t;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int ECS_CLK_MHZ       = 200;
  localparam int ECS_TICK_NS       = 1000;
  localparam int ECS_CLK_PERIOD_NS = 5;
  localparam int ECS_TICK_CYCLES   = ECS_TICK_NS / ECS_CLK_PERIOD_NS;
  localparam int ECS_COUNT_W       = 32;

endpackage : ecs_pkg

`default_nettype wire

// file: core/ecs_counter.sv
`timescale 1ns/1ps
`default_nettype none

module ecs_counter #(
  parameter int COUNT_W = ecs_pkg::ECS_COUNT_W
) (
  input  wire logic                REF_CLK,
  input  wire logic                RST_B,
  input  wire ecs_pkg::ecs_events_t EVENTS,
  input  wire logic                IO_INPUT_ONE,
  input  wire logic                IO_INPUT_TWO,
  input  wire ecs_pkg::ecs_config_t CONFIG,
  input  wire logic [COUNT_W-1:0]  COUNT_LIMIT,
  input  wire logic                CLEAR_CMD,
  output var  logic [COUNT_W-1:0]  COUNT_VALUE,
  output var  logic [4:0]          COUNT_STATUS,
  output var  logic                COUNT_DONE_EVENT
);

  if (COUNT_W < 2 || COUNT_W > 32) begin : g_bad_width
    $error("COUNT_W must be 2..32");
  end

  // ==========================================================================
  // Line synchronisers and edge detectors
  // ==========================================================================
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] line_prev;
  logic [7:0] ev_q;
  logic [7:0] ev;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync_a    <= 2'h0;
      sync_b    <= 2'h0;
      line_prev <= 2'h0;
    end else begin
      sync_a    <= {IO_INPUT_TWO, IO_INPUT_ONE};
      sync_b    <= sync_a;
      line_prev <= sync_b;
    end
  end

  wire [1:0] rise = sync_b & ~line_prev;
  wire [1:0] fall = ~sync_b & line_prev;

  function automatic logic edge_hit(input logic r, input logic f, input ecs_pkg::ecs_edge_t sel);
    edge_hit = (sel == ecs_pkg::ECS_EDGE_UP)   ? r :
               (sel == ecs_pkg::ECS_EDGE_DOWN) ? f :
               (sel == ecs_pkg::ECS_EDGE_EITHER) ? (r | f) : 1'b0;
  endfunction : edge_hit

  // Event strobes are treated as levels; a pulse is taken on their rise
  assign ev = EVENTS;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ev_q <= 8'h00;
    end else begin
      ev_q <= ev;
    end
  end
  wire ecs_pkg::ecs_events_t evp = ev & ~ev_q;

  // ==========================================================================
  // Microsecond tick
  // ==========================================================================
  localparam int TICK_W = $clog2(ecs_pkg::ECS_TICK_CYCLES);
  logic [TICK_W-1:0] tick_cnt;
  wire               usec_tick = (tick_cnt == TICK_W'(ecs_pkg::ECS_TICK_CYCLES - 1));

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= usec_tick ? '0 : tick_cnt + TICK_W'(1);
    end
  end

  // ==========================================================================
  // Source selection
  // ==========================================================================
  ecs_pkg::ecs_config_t cfg;
  assign cfg = CONFIG;
  logic done_q;

  wire l1_start = edge_hit(rise[0], fall[0], cfg.start_edge_select);
  wire l2_start = edge_hit(rise[1], fall[1], cfg.start_edge_select);
  wire l1_inc   = edge_hit(rise[0], fall[0], cfg.increment_edge_select);
  wire l2_inc   = edge_hit(rise[1], fall[1], cfg.increment_edge_select);
  wire l1_clr   = edge_hit(rise[0], fall[0], cfg.clear_edge_select);
  wire l2_clr   = edge_hit(rise[1], fall[1], cfg.clear_edge_select);

  logic start_fire;
  logic inc_fire;
  logic clr_fire;

  // Edge selection is only consulted in the line arms
  always_comb begin
    unique case (cfg.start_source_select)
      ecs_pkg::ECS_START_ACQ:      start_fire = evp.acq_begin_event;
      ecs_pkg::ECS_START_EXP_BEG:  start_fire = evp.expose_begin_event;
      ecs_pkg::ECS_START_EXP_FIN:  start_fire = evp.expose_finish_event;
      ecs_pkg::ECS_START_IMAGE:    start_fire = evp.image_begin_event;
      ecs_pkg::ECS_START_REJECT:   start_fire = evp.rejected_trigger_event;
      ecs_pkg::ECS_START_LINE_ONE: start_fire = l1_start;
      ecs_pkg::ECS_START_LINE_TWO: start_fire = l2_start;
      ecs_pkg::ECS_START_TIMER:    start_fire = evp.timer_one_done;
      ecs_pkg::ECS_START_COUNTER:  start_fire = done_q;
      default:                     start_fire = 1'b0;
    endcase
  end

  always_comb begin
    unique case (cfg.increment_source_select)
      ecs_pkg::ECS_INC_ACQ:      inc_fire = evp.acq_begin_event;
      ecs_pkg::ECS_INC_EXP_BEG:  inc_fire = evp.expose_begin_event;
      ecs_pkg::ECS_INC_EXP_FIN:  inc_fire = evp.expose_finish_event;
      ecs_pkg::ECS_INC_IMAGE:    inc_fire = evp.image_begin_event;
      ecs_pkg::ECS_INC_LINE_ONE: inc_fire = l1_inc;
      ecs_pkg::ECS_INC_LINE_TWO: inc_fire = l2_inc;
      ecs_pkg::ECS_INC_ENCODER:  inc_fire = evp.shaft_encoder_ticks;
      ecs_pkg::ECS_INC_USEC:     inc_fire = usec_tick;
      ecs_pkg::ECS_INC_TIMER:    inc_fire = evp.timer_one_done;
      ecs_pkg::ECS_INC_REJECT:   inc_fire = evp.rejected_trigger_event;
      default:                   inc_fire = 1'b0;
    endcase
  end

  always_comb begin
    unique case (cfg.clear_source_select)
      ecs_pkg::ECS_CLR_CMD:      clr_fire = CLEAR_CMD;
      ecs_pkg::ECS_CLR_ACQ_BEG:  clr_fire = evp.acq_begin_event;
      ecs_pkg::ECS_CLR_ACQ_FIN:  clr_fire = evp.acq_finish_event;
      ecs_pkg::ECS_CLR_EXP_BEG:  clr_fire = evp.expose_begin_event;
      ecs_pkg::ECS_CLR_EXP_FIN:  clr_fire = evp.expose_finish_event;
      ecs_pkg::ECS_CLR_LINE_ONE: clr_fire = l1_clr;
      ecs_pkg::ECS_CLR_LINE_TWO: clr_fire = l2_clr;
      ecs_pkg::ECS_CLR_TIMER:    clr_fire = evp.timer_one_done;
      ecs_pkg::ECS_CLR_COUNTER:  clr_fire = done_q;
      default:                   clr_fire = 1'b0;
    endcase
  end

  // ==========================================================================
  // Counter state machine
  // ==========================================================================
  ecs_pkg::ecs_state_t state;
  ecs_pkg::ecs_state_t next_state;
  logic [COUNT_W-1:0]  count;
  logic [COUNT_W-1:0]  next_count;
  logic                next_done;

  wire start_off = (cfg.start_source_select == ecs_pkg::ECS_START_OFF);
  wire at_max    = (count == {COUNT_W{1'b1}});
  wire inc_now   = inc_fire && (cfg.increment_source_select != ecs_pkg::ECS_INC_OFF);

  always_comb begin
    next_state = state;
    next_count = count;
    next_done  = 1'b0;
    if (clr_fire) begin
      next_count = '0;
      next_state = start_off ? ecs_pkg::ECS_ST_IDLE : ecs_pkg::ECS_ST_WAIT;
    end else begin
      unique case (state)
        ecs_pkg::ECS_ST_IDLE: begin
          if (!start_off) next_state = ecs_pkg::ECS_ST_WAIT;
        end
        ecs_pkg::ECS_ST_WAIT: begin
          if (start_off) begin
            next_state = ecs_pkg::ECS_ST_IDLE;
          end else if (start_fire) begin
            next_count = '0;
            next_state = ecs_pkg::ECS_ST_ACTIVE;
          end
        end
        ecs_pkg::ECS_ST_ACTIVE: begin
          if (inc_now) begin
            next_count = count + COUNT_W'(1);
            if (next_count == COUNT_LIMIT) begin
              next_done  = 1'b1;
              next_state = ecs_pkg::ECS_ST_DONE;
            end else if (next_count == {COUNT_W{1'b1}}) begin
              next_state = ecs_pkg::ECS_ST_OVERFLOW;
            end
          end
        end
        ecs_pkg::ECS_ST_DONE:     next_state = state;
        ecs_pkg::ECS_ST_OVERFLOW: next_state = state;
        default:                  next_state = ecs_pkg::ECS_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state  <= ecs_pkg::ECS_ST_IDLE;
      count  <= '0;
      done_q <= 1'b0;
    end else begin
      state  <= next_state;
      count  <= next_count;
      done_q <= next_done;
    end
  end

  assign COUNT_VALUE      = count;
  assign COUNT_STATUS     = state;
  assign COUNT_DONE_EVENT = done_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_off_holds;
    @(posedge REF_CLK) disable iff (!RST_B)
      (cfg.increment_source_select == ecs_pkg::ECS_INC_OFF && !clr_fire && !start_fire)
        |=> (count == $past(count));
  endproperty
  a_off_holds: assert property (p_off_holds) else $error("count moved with increment off");

  property p_clear_zero;
    @(posedge REF_CLK) disable iff (!RST_B)
      clr_fire |=> (count == '0) && (state != ecs_pkg::ECS_ST_ACTIVE);
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero and wait");

  property p_inc_one;
    @(posedge REF_CLK) disable iff (!RST_B)
      (state == ecs_pkg::ECS_ST_ACTIVE && inc_now && !clr_fire) |=> (count == $past(count) + 1'b1);
  endproperty
  a_inc_one: assert property (p_inc_one) else $error("active increment not by one");

  property p_done_limit;
    @(posedge REF_CLK) disable iff (!RST_B)
      COUNT_DONE_EVENT |-> (count == COUNT_LIMIT) && (state == ecs_pkg::ECS_ST_DONE);
  endproperty
  a_done_limit: assert property (p_done_limit) else $error("done without limit");

  property p_line_sync;
    @(posedge REF_CLK) disable iff (!RST_B)
      rise[0] |-> $past(IO_INPUT_ONE, 2) ##1 !rise[0];
  endproperty
  a_line_sync: assert property (p_line_sync) else $error("line edge longer than one cycle");

  property p_cmd_only;
    @(posedge REF_CLK) disable iff (!RST_B)
      (cfg.clear_source_select == ecs_pkg::ECS_CLR_CMD && !CLEAR_CMD &&
       state == ecs_pkg::ECS_ST_ACTIVE)
        |=> (state != ecs_pkg::ECS_ST_WAIT) && (state != ecs_pkg::ECS_ST_IDLE);
  endproperty
  a_cmd_only: assert property (p_cmd_only) else $error("cleared without command");

  property p_start_zero;
    @(posedge REF_CLK) disable iff (!RST_B)
      (state == ecs_pkg::ECS_ST_WAIT && start_fire && !clr_fire && !start_off)
        |=> (state == ecs_pkg::ECS_ST_ACTIVE) && (count == '0);
  endproperty
  a_start_zero: assert property (p_start_zero) else $error("start did not begin at zero");

  property p_usec;
    @(posedge REF_CLK) disable iff (!RST_B)
      // One microsecond is 200 reference cycles
      usec_tick |=> (!usec_tick) [*8] ##192 usec_tick;
  endproperty
  a_usec: assert property (p_usec) else $error("microsecond tick period wrong");

endmodule : ecs_counter

`default_nettype wire

// file: dv/ecs_src_model.sv
`timescale 1ns/1ps
`default_nettype none

module ecs_src_model (
  input  wire logic                 ref_clk,
  input  wire logic [7:0]           fire,
  input  wire logic                 lvl_one,
  input  wire logic                 lvl_two,
  output var  ecs_pkg::ecs_events_t events,
  output wire logic                 io_one,
  output wire logic                 io_two
);
  // ==========================================================================
  // Camera events and line pins
  // ==========================================================================
  // Sources inside the camera give one-cycle pulses with idle cycles between
  always @(posedge ref_clk) begin
    events <= ecs_pkg::ecs_events_t'(fire);
  end
  // Pins move off the clock grid so the synchroniser sees real skew
  assign #1.7 io_one = lvl_one;
  assign #1.7 io_two = lvl_two;
endmodule : ecs_src_model

`default_nettype wire

// file: dv/ecs_counter_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ecs_counter_tb;
  localparam int CW = 4;
  logic                  REF_CLK;
  logic                  RST_B;
  logic                  CLEAR_CMD;
  logic [7:0]            fire_bits;
  logic                  l1;
  logic                  l2;
  ecs_pkg::ecs_config_t  cfg;
  ecs_pkg::ecs_events_t  events;
  wire logic             io_one;
  wire logic             io_two;
  logic [CW-1:0]         limit;
  logic [CW-1:0]         value;
  logic [4:0]            status;
  logic                  done_ev;
  int                    err_count;
  int                    n_tests;
  int                    cyc;
  int                    n_done;
  ecs_pkg::ecs_inc_src_t inc_tab [7] = '{ecs_pkg::ECS_INC_ACQ, ecs_pkg::ECS_INC_EXP_BEG,
    ecs_pkg::ECS_INC_EXP_FIN, ecs_pkg::ECS_INC_IMAGE, ecs_pkg::ECS_INC_TIMER,
    ecs_pkg::ECS_INC_REJECT, ecs_pkg::ECS_INC_ENCODER};
  int                    inc_bit [7] = '{7, 5, 4, 3, 1, 2, 0};
  ecs_pkg::ecs_clr_src_t clr_tab [5] = '{ecs_pkg::ECS_CLR_ACQ_BEG, ecs_pkg::ECS_CLR_ACQ_FIN,
    ecs_pkg::ECS_CLR_EXP_BEG, ecs_pkg::ECS_CLR_EXP_FIN, ecs_pkg::ECS_CLR_TIMER};
  int                    clr_bit [5] = '{7, 6, 5, 4, 1};
  ecs_pkg::ecs_start_src_t st_tab [5] = '{ecs_pkg::ECS_START_ACQ, ecs_pkg::ECS_START_EXP_BEG,
    ecs_pkg::ECS_START_EXP_FIN, ecs_pkg::ECS_START_REJECT, ecs_pkg::ECS_START_TIMER};
  int                    st_bit [5] = '{7, 5, 4, 2, 1};

  ecs_counter #(.COUNT_W(CW)) ecs_counter_i (.REF_CLK(REF_CLK), .RST_B(RST_B),
    .EVENTS(events), .IO_INPUT_ONE(io_one), .IO_INPUT_TWO(io_two), .CONFIG(cfg),
    .COUNT_LIMIT(limit), .CLEAR_CMD(CLEAR_CMD), .COUNT_VALUE(value),
    .COUNT_STATUS(status), .COUNT_DONE_EVENT(done_ev));
  ecs_src_model ecs_src_model_i (.ref_clk(REF_CLK), .fire(fire_bits), .lvl_one(l1),
    .lvl_two(l2), .events(events), .io_one(io_one), .io_two(io_two));

  // ==========================================================================
  // Clock, watchdog and tasks
  // ==========================================================================
  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end

  // The whole sequence needs just under two thousand cycles; the ceiling leaves margin
  always @(posedge REF_CLK) begin
    cyc++;
    if (done_ev === 1'b1) n_done++;
    if (cyc == 10000) begin
      err_count++;
      complete_run();
    end
  end

  task complete_run;
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task chk(string name, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task tick(int n);
    repeat (n) @(posedge REF_CLK);
  endtask : tick

  // One event pulse, then idle cycles so the next rise is a fresh one
  task fire(int b);
    @(posedge REF_CLK) fire_bits <= 8'h01 << b;
    @(posedge REF_CLK) fire_bits <= 8'h00;
    tick(4);
  endtask : fire

  // Line paths need sync plus edge detect, so allow generous settling
  task line(int n, logic v);
    @(posedge REF_CLK);
    if (n == 1) l1 <= v;
    else l2 <= v;
    tick(8);
  endtask : line

  task cfg_clr(ecs_pkg::ecs_start_src_t s, ecs_pkg::ecs_edge_t se, ecs_pkg::ecs_inc_src_t i,
               ecs_pkg::ecs_edge_t ie, ecs_pkg::ecs_clr_src_t c);
    @(posedge REF_CLK);
    cfg.start_source_select     <= s;
    cfg.start_edge_select       <= se;
    cfg.increment_source_select <= i;
    cfg.increment_edge_select   <= ie;
    cfg.clear_source_select     <= ecs_pkg::ECS_CLR_CMD;
    CLEAR_CMD                   <= 1'b1;
    @(posedge REF_CLK) CLEAR_CMD <= 1'b0;
    tick(3);
    cfg.clear_source_select <= c;
  endtask : cfg_clr

  task arm(ecs_pkg::ecs_start_src_t s, ecs_pkg::ecs_inc_src_t i, ecs_pkg::ecs_edge_t ie,
           ecs_pkg::ecs_clr_src_t c, ecs_pkg::ecs_edge_t ce);
    cfg_clr(s, ecs_pkg::ECS_EDGE_EITHER, i, ie, c);
    cfg.clear_edge_select <= ce;
    if (s == ecs_pkg::ECS_START_LINE_TWO) line(2, ~l2);
    else fire(3);
    chk("status after start", 8'h04, 8'(status));
  endtask : arm

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    RST_B = 1'b0; CLEAR_CMD = 1'b0; fire_bits = 8'h00; l1 = 1'b0; l2 = 1'b0;
    cfg = '0; limit = '0; err_count = 0; n_tests = 0; cyc = 0; n_done = 0;
    tick(4);
    RST_B <= 1'b1;
    tick(2);
    chk("status idle", 8'h01, 8'(status));
    limit <= 4'h3;
    arm(ecs_pkg::ECS_START_LINE_TWO, ecs_pkg::ECS_INC_EXP_BEG, ecs_pkg::ECS_EDGE_UP,
        ecs_pkg::ECS_CLR_CMD, ecs_pkg::ECS_EDGE_UP);
    fire(5);
    fire(5);
    chk("count", 8'h02, 8'(value));
    fire(5);
    chk("count at limit", 8'h03, 8'(value));
    chk("status done", 8'h08, 8'(status));
    fire(5);
    chk("done pulses", 8'h01, 8'(n_done));
    chk("count held", 8'h03, 8'(value));
    limit <= 4'h0;
    for (int k = 0; k < 7; k++) begin
      arm(ecs_pkg::ECS_START_LINE_TWO, inc_tab[k], ecs_pkg::ECS_EDGE_UP,
          ecs_pkg::ECS_CLR_CMD, ecs_pkg::ECS_EDGE_UP);
      fire(inc_bit[k]);
      fire(6);
      chk("event count", 8'h01, 8'(value));
    end
    @(posedge REF_CLK) cfg.increment_source_select <= ecs_pkg::ECS_INC_OFF;
    fire(0);
    chk("count stopped", 8'h01, 8'(value));
    arm(ecs_pkg::ECS_START_LINE_TWO, ecs_pkg::ECS_INC_USEC, ecs_pkg::ECS_EDGE_UP,
        ecs_pkg::ECS_CLR_CMD, ecs_pkg::ECS_EDGE_UP);
    tick(1000);
    chk("tick count 5..6", 8'h01, 8'(value >= 4'h5 && value <= 4'h6));
    for (int e = 0; e < 3; e++) begin
      arm(ecs_pkg::ECS_START_IMAGE, ecs_pkg::ECS_INC_LINE_ONE, ecs_pkg::ecs_edge_t'(e),
          ecs_pkg::ECS_CLR_CMD, ecs_pkg::ECS_EDGE_UP);
      line(1, 1'b1);
      line(1, 1'b0);
      chk("line count", (e == 2) ? 8'h02 : 8'h01, 8'(value));
    end
    // The start toggles leave line two high; bring it low so a rise comes first
    line(2, 1'b0);
    arm(ecs_pkg::ECS_START_IMAGE, ecs_pkg::ECS_INC_LINE_TWO, ecs_pkg::ECS_EDGE_UP,
        ecs_pkg::ECS_CLR_CMD, ecs_pkg::ECS_EDGE_UP);
    line(2, 1'b1);
    line(2, 1'b0);
    chk("line two count", 8'h01, 8'(value));
    cfg_clr(ecs_pkg::ECS_START_LINE_TWO, ecs_pkg::ECS_EDGE_DOWN, ecs_pkg::ECS_INC_ENCODER,
            ecs_pkg::ECS_EDGE_UP, ecs_pkg::ECS_CLR_CMD);
    line(2, 1'b1);
    chk("status on rise", 8'h02, 8'(status));
    line(2, 1'b0);
    chk("status on fall", 8'h04, 8'(status));
    for (int k = 0; k < 5; k++) begin
      cfg_clr(st_tab[k], ecs_pkg::ECS_EDGE_DOWN, ecs_pkg::ECS_INC_ENCODER,
              ecs_pkg::ECS_EDGE_UP, ecs_pkg::ECS_CLR_CMD);
      fire(6);
      chk("no start on other event", 8'h02, 8'(status));
      fire(st_bit[k]);
      chk("event start", 8'h04, 8'(status));
    end
    cfg_clr(ecs_pkg::ECS_START_LINE_ONE, ecs_pkg::ECS_EDGE_UP, ecs_pkg::ECS_INC_ENCODER,
            ecs_pkg::ECS_EDGE_UP, ecs_pkg::ECS_CLR_CMD);
    line(1, 1'b1);
    chk("line one start", 8'h04, 8'(status));
    line(1, 1'b0);
    for (int k = 0; k < 5; k++) begin
      arm(ecs_pkg::ECS_START_LINE_TWO, ecs_pkg::ECS_INC_ENCODER, ecs_pkg::ECS_EDGE_UP,
          clr_tab[k], ecs_pkg::ECS_EDGE_UP);
      fire(0);
      chk("count", 8'h01, 8'(value));
      fire(clr_bit[k]);
      chk("cleared", 8'h00, 8'(value));
      chk("status wait", 8'h02, 8'(status));
      fire(0);
      chk("no count in wait", 8'h00, 8'(value));
    end
    for (int e = 0; e < 3; e++) begin
      arm(ecs_pkg::ECS_START_LINE_TWO, ecs_pkg::ECS_INC_ENCODER, ecs_pkg::ECS_EDGE_UP,
          ecs_pkg::ECS_CLR_LINE_ONE, ecs_pkg::ecs_edge_t'(e));
      fire(0);
      line(1, 1'b1);
      chk("line clear rise", (e == 1) ? 8'h01 : 8'h00, 8'(value));
      line(1, 1'b0);
      chk("line clear fall", 8'h00, 8'(value));
    end
    arm(ecs_pkg::ECS_START_IMAGE, ecs_pkg::ECS_INC_ENCODER, ecs_pkg::ECS_EDGE_UP,
        ecs_pkg::ECS_CLR_LINE_TWO, ecs_pkg::ECS_EDGE_UP);
    fire(0);
    chk("count before line two clear", 8'h01, 8'(value));
    line(2, 1'b1);
    chk("line two clear", 8'h00, 8'(value));
    chk("line two clear wait", 8'h02, 8'(status));
    arm(ecs_pkg::ECS_START_LINE_TWO, ecs_pkg::ECS_INC_ENCODER, ecs_pkg::ECS_EDGE_UP,
        ecs_pkg::ECS_CLR_CMD, ecs_pkg::ECS_EDGE_UP);
    fire(0);
    fire(7);
    fire(4);
    chk("events ignored", 8'h01, 8'(value));
    @(posedge REF_CLK) CLEAR_CMD <= 1'b1;
    @(posedge REF_CLK) CLEAR_CMD <= 1'b0;
    tick(3);
    chk("command clear", 8'h00, 8'(value));
    limit <= 4'h1;
    arm(ecs_pkg::ECS_START_LINE_TWO, ecs_pkg::ECS_INC_ENCODER, ecs_pkg::ECS_EDGE_UP,
        ecs_pkg::ECS_CLR_COUNTER, ecs_pkg::ECS_EDGE_UP);
    fire(0);
    chk("done clears", 8'h02, 8'(status));
    limit <= 4'h0;
    arm(ecs_pkg::ECS_START_LINE_TWO, ecs_pkg::ECS_INC_ENCODER, ecs_pkg::ECS_EDGE_UP,
        ecs_pkg::ECS_CLR_CMD, ecs_pkg::ECS_EDGE_UP);
    repeat (15) fire(0);
    chk("count full", 8'h0F, 8'(value));
    chk("status overflow", 8'h10, 8'(status));
    complete_run();
  end
endmodule : ecs_counter_tb

`default_nettype wire
